/* design/dpa_port_ctrl.sv */
// Port controller driving one side of a dual-port memory
// Contract
// - Write strobe stays high through every read, array or flag latch.
// - Flag latch reads always use an explicit select, never address-only.
// - Address is valid before or with the falling select.
// - Write strobe is high whenever the address changes.
// - Controller does not drive data while device may still drive pins.
// - After a flag write, selects stay high at least 10 ns before reading.
// - At least 5 ns between flag write end and next flag read.
// - Strobe may rise no earlier than busy is released.
// - After busy rises, strobe stays low at least 15 ns more.
// - Array: memory select low, flag select high; flag latch reverse.
`timescale 1ns/100ps
module dpa_port_ctrl #(
  parameter int ADDR_W = dpa_pkg::ADDR_W,
  parameter int DATA_W = dpa_pkg::DATA_W
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  input  wire logic              I_REQ_VALID,
  input  wire logic              I_REQ_WRITE,
  input  wire logic              I_REQ_FLAG,
  input  wire logic [ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [DATA_W-1:0] I_REQ_WDATA,
  output logic                   O_REQ_READY,
  output logic                   O_DONE,
  output logic      [DATA_W-1:0] O_RDATA,
  output logic                   O_IRQ,
  output logic      [ADDR_W-1:0] O_ADDR,
  output logic                   O_MEM_SEL_N,
  output logic                   O_FLAG_LATCH_SELECT_N,
  output logic                   O_WR_N,
  output logic                   O_OE_N,
  output logic      [DATA_W-1:0] O_DQ,
  output logic                   O_DQ_OE_N,
  input  wire logic [DATA_W-1:0] I_DQ,
  input  wire logic              I_BUSY_N,
  input  wire logic              I_INT_N
);
  dpa_pkg::dpa_regs_t r;
  dpa_pkg::dpa_regs_t next_r;

  function automatic dpa_pkg::dpa_pins_t idle_pins(
    input dpa_pkg::dpa_pins_t p);
    dpa_pkg::dpa_pins_t q;
    q = p;
    q.mem_sel_n = 1'b1;
    q.flag_latch_select_n = 1'b1;
    q.wr_n = 1'b1;
    q.oe_n = 1'b1;
    q.dq_oe_n = 1'b1;
    return q;
  endfunction

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.irq = ~I_INT_N;
    next_r.cnt = (r.cnt == dpa_pkg::ZERO_C) ? r.cnt : r.cnt - dpa_pkg::ONE_C;
    case (r.state)
      dpa_pkg::DPA_IDLE: begin
        if (I_REQ_VALID) begin
          next_r.req.write = I_REQ_WRITE;
          next_r.req.flag = I_REQ_FLAG;
          next_r.req.addr = I_REQ_ADDR;
          next_r.req.wdata = I_REQ_WDATA;
          next_r.ready = 1'b0;
          // Address changes only with every strobe and select high
          next_r.pins = idle_pins(r.pins);
          next_r.pins.addr = I_REQ_ADDR;
          next_r.cnt = dpa_pkg::CYC_SETUP_C;
          next_r.state = dpa_pkg::DPA_SETUP;
        end
      end
      dpa_pkg::DPA_SETUP: begin
        // Flag read after flag write waits out the update pulse
        if (r.cnt == dpa_pkg::ZERO_C) begin
          if (r.req.write) begin
            // Strobe low first, select after: device keeps outputs off
            next_r.pins.wr_n = 1'b0;
            next_r.pins.dq_oe_n = 1'b0;
            next_r.pins.dq_out = r.req.wdata;
            next_r.cnt = dpa_pkg::CYC_PULSE_C;
            next_r.state = dpa_pkg::DPA_WRITE;
          end else begin
            next_r.pins.wr_n = 1'b1;
            next_r.pins.oe_n = 1'b0;
            next_r.pins.mem_sel_n = r.req.flag;
            next_r.pins.flag_latch_select_n = ~r.req.flag;
            next_r.cnt = dpa_pkg::CYC_ACCESS_C;
            next_r.state = dpa_pkg::DPA_READ;
          end
        end
      end
      dpa_pkg::DPA_READ: begin
        // Access time restarts while busy holds the port off
        if (!I_BUSY_N) begin
          next_r.cnt = dpa_pkg::CYC_ACCESS_C;
        end else if (r.cnt == dpa_pkg::ZERO_C) begin
          next_r.rdata = I_DQ;
          next_r.done = 1'b1;
          next_r.pins = idle_pins(r.pins);
          next_r.last_flag_wr = 1'b0;
          next_r.cnt = dpa_pkg::ZERO_C;
          next_r.state = dpa_pkg::DPA_GAP;
        end
      end
      dpa_pkg::DPA_WRITE: begin
        // Select follows the strobe by one cycle
        if (r.pins.mem_sel_n && r.pins.flag_latch_select_n) begin
          next_r.pins.mem_sel_n = r.req.flag;
          next_r.pins.flag_latch_select_n = ~r.req.flag;
        end
        // Busy low stalls the strobe; release needs a hold afterwards
        if (!I_BUSY_N) begin
          next_r.cnt = dpa_pkg::CYC_WH_C;
        end else if (r.cnt == dpa_pkg::ZERO_C &&
                     !(r.pins.mem_sel_n && r.pins.flag_latch_select_n)) begin
          next_r.pins.wr_n = 1'b1;
          next_r.pins.mem_sel_n = 1'b1;
          next_r.pins.flag_latch_select_n = 1'b1;
          next_r.state = dpa_pkg::DPA_HOLD;
        end
      end
      dpa_pkg::DPA_HOLD: begin
        next_r.pins = idle_pins(r.pins);
        next_r.done = 1'b1;
        next_r.last_flag_wr = r.req.flag;
        next_r.cnt = r.req.flag ? dpa_pkg::CYC_GAP_C : dpa_pkg::ZERO_C;
        next_r.state = dpa_pkg::DPA_GAP;
      end
      dpa_pkg::DPA_GAP: begin
        if (r.cnt == dpa_pkg::ZERO_C) begin
          next_r.ready = 1'b1;
          next_r.state = dpa_pkg::DPA_IDLE;
        end
      end
      default: begin
        next_r.pins = idle_pins(r.pins);
        next_r.state = dpa_pkg::DPA_IDLE;
      end
    endcase
    // Flag read right after flag write keeps selects high longer
    if (r.state == dpa_pkg::DPA_IDLE && I_REQ_VALID && r.last_flag_wr &&
        I_REQ_FLAG && !I_REQ_WRITE) begin
      next_r.cnt = dpa_pkg::CYC_SETUP_C + dpa_pkg::CYC_GAP_C;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      r.state <= dpa_pkg::DPA_IDLE;
      r.cnt <= '0;
      r.last_flag_wr <= 1'b0;
      r.req <= '0;
      r.pins.mem_sel_n <= 1'b1;
      r.pins.flag_latch_select_n <= 1'b1;
      r.pins.wr_n <= 1'b1;
      r.pins.oe_n <= 1'b1;
      r.pins.dq_oe_n <= 1'b1;
      r.pins.addr <= '0;
      r.pins.dq_out <= '0;
      r.ready <= 1'b1;
      r.done <= 1'b0;
      r.rdata <= '0;
      r.irq <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign O_REQ_READY = r.ready;
  assign O_DONE = r.done;
  assign O_RDATA = r.rdata;
  assign O_IRQ = r.irq;
  assign O_ADDR = r.pins.addr;
  assign O_MEM_SEL_N = r.pins.mem_sel_n;
  assign O_FLAG_LATCH_SELECT_N = r.pins.flag_latch_select_n;
  assign O_WR_N = r.pins.wr_n;
  assign O_OE_N = r.pins.oe_n;
  assign O_DQ = r.pins.dq_out;
  assign O_DQ_OE_N = r.pins.dq_oe_n;

  wire sel_low = !O_MEM_SEL_N || !O_FLAG_LATCH_SELECT_N;

  property p_read_no_strobe;
    @(posedge I_CLK) disable iff (!I_RST_N)
      !O_OE_N |-> O_WR_N;
  endproperty
  a_read_no_strobe: assert property (p_read_no_strobe)
    else $error("Strobe low during read");

  property p_flag_read_select;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (!O_OE_N && r.req.flag) |-> !O_FLAG_LATCH_SELECT_N;
  endproperty
  a_flag_read_select: assert property (p_flag_read_select)
    else $error("Flag read without select");

  property p_addr_stable;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (O_ADDR != $past(O_ADDR)) |-> (O_WR_N && $past(O_WR_N) && !sel_low);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("Address moved while selected");

  property p_select_excl;
    @(posedge I_CLK) disable iff (!I_RST_N)
      !(!O_MEM_SEL_N && !O_FLAG_LATCH_SELECT_N);
  endproperty
  a_select_excl: assert property (p_select_excl)
    else $error("Both selects low");

  property p_strobe_first;
    @(posedge I_CLK) disable iff (!I_RST_N)
      $fell(O_WR_N) |-> (!O_DQ_OE_N && !sel_low ##1 sel_low);
  endproperty
  a_strobe_first: assert property (p_strobe_first)
    else $error("Select fell before strobe");

  property p_busy_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (!O_WR_N && $rose(I_BUSY_N)) |-> !O_WR_N [*2];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Strobe rose too soon after busy");

  property p_no_rise_busy;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (!O_WR_N && !I_BUSY_N) |=> !O_WR_N;
  endproperty
  a_no_rise_busy: assert property (p_no_rise_busy)
    else $error("Strobe rose while busy");

  property p_flag_gap;
    @(posedge I_CLK) disable iff (!I_RST_N)
      ($rose(O_FLAG_LATCH_SELECT_N) && r.req.write) |->
        O_FLAG_LATCH_SELECT_N [*2];
  endproperty
  a_flag_gap: assert property (p_flag_gap)
    else $error("Flag select reopened too soon");
endmodule

/* design/dpa_pkg.sv */
// Package for the dual-port memory port controller
package dpa_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int CLK_NS = 20;
  // Timing figures in ns
  localparam int T_SETUP_NS   = 20;
  localparam int T_ACCESS_NS  = 20;
  localparam int T_PULSE_NS   = 15;
  localparam int T_SOP_NS     = 10;
  localparam int T_SWRD_NS    = 5;
  localparam int T_WH_NS      = 15;
  localparam int CYC_SETUP  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int CYC_PULSE  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SOP    = (T_SOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SWRD   = (T_SWRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WH     = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [3:0] CYC_SETUP_C  = 4'(CYC_SETUP);
  localparam logic [3:0] CYC_ACCESS_C = 4'(CYC_ACCESS);
  localparam logic [3:0] CYC_PULSE_C  = 4'(CYC_PULSE);
  localparam logic [3:0] CYC_GAP_C    = 4'(CYC_SOP > CYC_SWRD ?
                                           CYC_SOP : CYC_SWRD);
  localparam logic [3:0] CYC_WH_C     = 4'(CYC_WH);
  localparam logic [3:0] ONE_C        = 4'h1;
  localparam logic [3:0] ZERO_C       = 4'h0;

  typedef enum logic [5:0] {
    DPA_IDLE   = 6'h01,
    DPA_SETUP  = 6'h02,
    DPA_READ   = 6'h04,
    DPA_WRITE  = 6'h08,
    DPA_HOLD   = 6'h10,
    DPA_GAP    = 6'h20
  } dpa_state_t;

  typedef struct packed {
    logic              write;
    logic              flag;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpa_req_t;

  typedef struct packed {
    logic              mem_sel_n;
    logic              flag_latch_select_n;
    logic              wr_n;
    logic              oe_n;
    logic              dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
  } dpa_pins_t;

  typedef struct packed {
    dpa_state_t        state;
    logic [CNT_W-1:0]  cnt;
    logic              last_flag_wr;
    dpa_req_t          req;
    dpa_pins_t         pins;
    logic              ready;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic              irq;
  } dpa_regs_t;
endpackage

/* sim/dpa_dev_model.sv */
// Behavioural model of one port of the dual-port memory
`timescale 1ns/100ps
module dpa_dev_model (
  input  wire logic [16:0] i_addr,
  input  wire logic        i_mem_sel_n,
  input  wire logic        i_flag_sel_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_oe_n,
  input  wire logic [8:0]  i_dq,
  input  wire logic        i_busy,
  input  wire logic        i_mail,
  input  wire logic [7:0]  i_other_owns,
  output logic      [8:0]  o_dq,
  output logic             o_busy_n,
  output logic             o_int_n
);
  logic [8:0] mem [int];
  logic [7:0] mine = 8'h00;
  logic [8:0] drv;
  logic [8:0] last = 9'h000;
  wire        sel = !i_mem_sel_n || !i_flag_sel_n;
  wire        wr  = !i_wr_n && sel;
  wire        rd  = !i_oe_n && i_wr_n && sel;
  wire        clr = rd && !i_mem_sel_n && i_addr == 17'h1FFFE;
  assign o_busy_n = !i_busy;
  initial o_int_n = 1'h1;
  always @(posedge i_mail or posedge clr) o_int_n = !i_mail;
  always @* begin
    if (wr && !i_mem_sel_n) mem[i_addr] = i_dq;
    if (wr && !i_flag_sel_n) begin
      mine[i_addr[2:0]] = !i_dq[0] && !i_other_owns[i_addr[2:0]];
    end
  end
  always @* begin
    if (!i_mem_sel_n) drv = mem.exists(i_addr) ? mem[i_addr] : 9'h000;
    else drv = {9{!mine[i_addr[2:0]]}};
  end
  // Released lines show the inverse of what was last driven
  always @* if (rd && !i_busy) last = drv;
  assign o_dq = (rd && !i_busy) ? drv : ~last;
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the dual-port port controller
`timescale 1ns/100ps
module tb_top;
  logic        I_CLK = 0;
  logic        I_RST_N = 0;
  logic        v = 0, w = 0, f = 0, busy = 0, mail = 0;
  logic [16:0] ra = '0, pa = '0;
  logic [8:0]  wd = '0, got;
  logic [7:0]  oth = '0;
  logic        pw = 1, ps = 1, pf = 1;
  realtime     tfw = 0;
  wire  [8:0]  dev_dq, bus, rdata, dq;
  wire  [16:0] addr;
  wire         rdy, done, irq, ms_n, fs_n, wr_n, oe_n, dq_oe_n, busy_n, int_n;
  int          fails = 0, checked = 0, l0, l1;
  logic [8:0]  exp_q [8];
  logic [16:0] adr_q [8];
  assign bus = !dq_oe_n ? dq : dev_dq;
  initial forever #10 I_CLK = !I_CLK;
  dpa_port_ctrl u_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ_VALID(v),
    .I_REQ_WRITE(w), .I_REQ_FLAG(f), .I_REQ_ADDR(ra), .I_REQ_WDATA(wd),
    .O_REQ_READY(rdy), .O_DONE(done), .O_RDATA(rdata), .O_IRQ(irq),
    .O_ADDR(addr), .O_MEM_SEL_N(ms_n), .O_FLAG_LATCH_SELECT_N(fs_n),
    .O_WR_N(wr_n), .O_OE_N(oe_n), .O_DQ(dq), .O_DQ_OE_N(dq_oe_n),
    .I_DQ(bus), .I_BUSY_N(busy_n), .I_INT_N(int_n));
  dpa_dev_model u_dev (.i_addr(addr), .i_mem_sel_n(ms_n), .i_flag_sel_n(fs_n),
    .i_wr_n(wr_n), .i_oe_n(oe_n), .i_dq(bus), .i_busy(busy), .i_mail(mail),
    .i_other_owns(oth), .o_dq(dev_dq), .o_busy_n(busy_n), .o_int_n(int_n));
  task automatic end_of_test;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_data(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_data({8'h00, g}, {8'h00, e});
  endtask
  task automatic xfer(input logic iw, input logic ifl, input logic [16:0] a,
                      input logic [8:0] d, output int lat);
    lat = 0;
    while (rdy !== 1'h1 && lat < 60) begin
      @(negedge I_CLK);
      lat++;
    end
    if (lat < 60) begin
      {v, w, f, ra, wd} = {1'h1, iw, ifl, a, d};
      @(negedge I_CLK);
      v = 0;
      lat = 1;
      while (done !== 1'h1 && lat < 60) begin
        @(negedge I_CLK);
        lat++;
      end
    end
    if (lat >= 60) begin
      fails++;
      end_of_test;
    end else begin
      got = rdata;
    end
  endtask
  // Busy held low for four cycles, starting inside the access
  task automatic pulse_busy;
    repeat (3) @(negedge I_CLK);
    busy = 1;
    repeat (4) @(negedge I_CLK);
    busy = 0;
  endtask
  // Pin-level watch on every settled cycle
  always @(negedge I_CLK) if (I_RST_N) begin
    if (!oe_n) cmp_bit(wr_n & dq_oe_n, 1'h1);
    if (addr !== pa) cmp_bit(wr_n & pw, 1'h1);
    if (ps && !(ms_n & fs_n)) cmp_bit(addr === pa, 1'h1);
    cmp_bit(ms_n | fs_n, 1'h1);
    if (!pf && !pw && fs_n) tfw = $realtime;
    if (pf && !fs_n && wr_n)
      cmp_bit($realtime - tfw >= 10, 1'h1);
    {pw, ps, pf, pa} = {wr_n, ms_n & fs_n, fs_n, addr};
  end
  initial begin
    void'($urandom(63789));
    repeat (16) @(negedge I_CLK);
    cmp_bit(rdy & ms_n & fs_n & wr_n & oe_n & dq_oe_n & !irq, 1'h1);
    I_RST_N = 1;
    for (int i = 0; i < 8; i++) begin
      adr_q[i] = (i == 0) ? 17'h00000 : 17'($urandom_range(17'h1FFFD, 1));
      exp_q[i] = 9'($urandom);
      xfer(1, 0, adr_q[i], exp_q[i], l0);
    end
    for (int i = 0; i < 8; i++) begin
      xfer(0, 0, adr_q[i], 9'h000, l0);
      cmp_data(got, exp_q[i]);
    end
    for (int k = 0; k < 8; k++) begin
      oth = 8'($urandom);
      xfer(1, 1, 17'(k), 9'h000, l0);
      xfer(0, 1, 17'(k), 9'h000, l0);
      cmp_data(got, {9{oth[k]}});
      xfer(1, 1, 17'(k), 9'h001, l0);
      xfer(0, 1, 17'(k), 9'h000, l0);
      cmp_data(got, 9'h1FF);
    end
    xfer(0, 0, adr_q[3], 9'h000, l0);
    fork
      xfer(0, 0, adr_q[3], 9'h000, l1);
      pulse_busy;
    join
    cmp_data(got, exp_q[3]);
    cmp_bit(l1 > l0, 1'h1);
    // Write stalled by busy, then read back
    xfer(1, 0, adr_q[5], exp_q[5], l0);
    fork
      xfer(1, 0, adr_q[5], ~exp_q[5], l1);
      pulse_busy;
    join
    cmp_bit(l1 > l0, 1'h1);
    xfer(0, 0, adr_q[5], 9'h000, l0);
    cmp_data(got, ~exp_q[5]);
    mail = 1;
    @(negedge I_CLK);
    mail = 0;
    repeat (2) @(negedge I_CLK);
    cmp_bit(irq, 1'h1);
    xfer(0, 0, 17'h1FFFF, 9'h000, l0);
    repeat (2) @(negedge I_CLK);
    cmp_bit(irq, 1'h1);
    xfer(0, 0, 17'h1FFFE, 9'h000, l0);
    repeat (2) @(negedge I_CLK);
    cmp_bit(irq, 1'h0);
    end_of_test;
  end
endmodule
